/* File: shared/tac_map.svh */
// Register offsets, field positions and timing constants for abort capture
`ifndef TAC_MAP_SVH
`define TAC_MAP_SVH
// Register word offsets (byte addresses, word aligned)
`define TAC_OFF_CAUSE 8'h80
`define TAC_OFF_CLR_ABRT 8'h54
`define TAC_OFF_CLR_ALL 8'h40
`define TAC_OFF_CTRL 8'h00
`define TAC_OFF_TARGET 8'h04
`define TAC_OFF_INT_STAT 8'h2C
`define TAC_OFF_INT_MASK 8'h30
`define TAC_OFF_CMD 8'h10
// Cause bit positions
`define TAC_B_7B_NOACK 0
`define TAC_B_10A1_NOACK 1
`define TAC_B_10A2_NOACK 2
`define TAC_B_DATA_NOACK 3
`define TAC_B_GC_NOACK 4
`define TAC_B_GC_READ 5
`define TAC_B_HS_ACK 6
`define TAC_B_SB_ACK 7
`define TAC_B_HS_NORS 8
`define TAC_B_SB_NORS 9
`define TAC_B_10RD_NORS 10
`define TAC_B_MST_DIS 11
// Control register fields
`define TAC_CTL_MASTER_EN 0
`define TAC_CTL_TENBIT 4
`define TAC_CTL_RESTART_EN 5
`define TAC_CTL_HS_MODE 6
// Target register fields
`define TAC_TAR_GC_OR_SB 10
`define TAC_TAR_COMMAND_FLAG_A 11
// Command register fields
`define TAC_CMD_READ 9
// Reset values
`define TAC_CTL_RESET 32'h0000_0020
`define TAC_ZERO32 32'h0000_0000
// Cycles between bus-clock edge and sampling ACK inside the engine
`define TAC_SYNC_STAGES 2
`endif

/* File: shared/tac_pkg.sv */
// Types shared by the abort-cause capture block
package tac_pkg;
    // Bus-engine phase events reported on a sampled link clock edge
    typedef struct packed {
        logic addr7_nack;      // 7-bit address byte not acked
        logic addr10a_nack;    // First 10-bit address byte not acked
        logic addr10b_nack;    // Second 10-bit address byte not acked
        logic data_nack;       // Data byte not acked
        logic gcall_nack;      // General call not acked
        logic startbyte_ack;   // START byte acked
        logic hscode_ack;      // High-speed master code acked
    } tac_bus_evt_t;
    // Byte phase tracked on the link
    typedef enum logic [2:0] {
        TAC_PH_IDLE,
        TAC_PH_ADDR7,
        TAC_PH_ADDR10A,
        TAC_PH_ADDR10B,
        TAC_PH_DATA,
        TAC_PH_GCALL,
        TAC_PH_SBYTE,
        TAC_PH_HSCODE
    } tac_phase_t;
endpackage : tac_pkg

/* File: logic/tac_ack_sampler.sv */
// Link clock synchroniser and acknowledge-slot sampler
`timescale 1ns/1ns
module tac_ack_sampler
    import tac_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic ack_slot_i,
    input wire tac_phase_t phase_i,
    output tac_bus_evt_t evt_o
);
    logic [1:0] scl_sync_q;   // Two-flop synchroniser for SCL
    logic [1:0] sda_sync_q;   // Two-flop synchroniser for SDA
    logic scl_prev_q;         // Previous synchronised SCL
    logic rise_w;             // Rising SCL edge
    logic nack_w;             // SDA high at ACK slot means no ack
    tac_bus_evt_t evt_d;

    // Only the second stage is read by logic
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // Idle bus level, so no false SCL edge follows reset
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
        end
    end

    assign rise_w = scl_sync_q[1] & ~scl_prev_q & ack_slot_i;
    assign nack_w = sda_sync_q[1];

    // Classify ACK slot by the byte phase in flight
    always_comb begin
        evt_d = '0;
        if (rise_w) begin
            unique case (phase_i)
                TAC_PH_ADDR7: evt_d.addr7_nack = nack_w;
                TAC_PH_ADDR10A: evt_d.addr10a_nack = nack_w;
                TAC_PH_ADDR10B: evt_d.addr10b_nack = nack_w;
                TAC_PH_DATA: evt_d.data_nack = nack_w;
                TAC_PH_GCALL: evt_d.gcall_nack = nack_w;
                // A START byte must never be acked
                TAC_PH_SBYTE: evt_d.startbyte_ack = ~nack_w;
                // Nobody may ack the HS master code
                TAC_PH_HSCODE: evt_d.hscode_ack = ~nack_w;
                TAC_PH_IDLE: evt_d = '0;
            endcase
        end
    end

    // One-cycle event pulses, registered
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) evt_o <= '0;
        else evt_o <= evt_d;
    end
endmodule : tac_ack_sampler

/* File: logic/tac_abort_capture.sv */
// Transmit abort cause capture with Avalon-MM registers and interrupt
//
// Behaviour
// R01: Master start while master disabled sets bit 11
// R02: Ten-bit read without restart sets bit 10
// R03: START byte without restart sets bit 9
// R04: Bit 9 re-sets after one cycle if cause persists
// R05: Bit 9 cause gone via restart, flag, select
// R06: High-speed transfer without restart sets bit 8
// R07: Acked START byte sets bit 7
// R08: Acked high-speed master code sets bit 6; the code sets it only while high-speed mode is on
// R09: General call followed by read sets bit 5
// R10: Unacked general call sets bit 4
// R11: Unacked data byte after acked address sets bit 3
// R12: Unacked second ten-bit address byte sets bit 2
// R13: Unacked first ten-bit address byte sets bit 1
// R14: Unacked seven-bit address sets bit 0
// R15: Clear-abort or clear-all read clears causes
// R16: Any cause raises the transmit abort flag
// R17: Causes reset to zero, writes ignored
`include "tac_map.svh"
`timescale 1ns/1ns
module tac_abort_capture
    import tac_pkg::*;
#(
    parameter int CAUSE_W = 12
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Master engine requests (same clock domain)
    input wire logic start_req_i,
    input wire logic cmd_push_i,
    input wire logic cmd_read_i,
    input wire logic ack_slot_i,
    input wire tac_phase_t phase_i,
    // I2C pins, from outside the clock domain
    input wire logic scl_i,
    input wire logic sda_i,
    // Outputs
    output logic tx_abort_o,
    output logic irq_o
);
    logic [CAUSE_W-1:0] cause_q;     // Abort cause bits
    logic [CAUSE_W-1:0] cause_d;
    logic [CAUSE_W-1:0] set_w;       // Hardware set terms
    logic [31:0] ctrl_q;             // controller_config
    logic [31:0] target_q;           // target_address_config
    logic gc_sent_q;                 // General call sent, awaiting cmd
    logic [1:0] int_stat_q;          // Sticky events: 0 abort, 1 sb stuck
    logic [1:0] int_mask_q;
    logic [1:0] int_stat_d;
    logic [31:0] rdata_d;
    logic ack_q;                     // Answer phase flag
    logic wait_q;                    // Registered waitrequest, high idle
    logic abort_q;
    logic irq_q;
    tac_bus_evt_t evt_w;

    // Decoded controls
    wire master_en_w = ctrl_q[`TAC_CTL_MASTER_EN];
    wire restart_en_w = ctrl_q[`TAC_CTL_RESTART_EN];
    wire tenbit_w = ctrl_q[`TAC_CTL_TENBIT];
    wire hs_mode_w = ctrl_q[`TAC_CTL_HS_MODE];
    wire command_flag_a_w = target_q[`TAC_TAR_COMMAND_FLAG_A];
    wire gc_or_sb_w = target_q[`TAC_TAR_GC_OR_SB];
    // Start-byte request pending while restart is off
    wire sb_cause_w = ~restart_en_w & command_flag_a_w & gc_or_sb_w; // [R05]
    wire gc_mode_w = command_flag_a_w & ~gc_or_sb_w;

    // Bus handshake: one wait cycle, then answer
    wire req_w = (avs_read_i | avs_write_i) & ~ack_q;
    wire rd_take_w = avs_read_i & ack_q;
    wire wr_take_w = avs_write_i & ack_q;
    wire clr_abrt_w = rd_take_w & ((avs_address_i == `TAC_OFF_CLR_ABRT) |
                      (avs_address_i == `TAC_OFF_CLR_ALL)); // [R15]
    wire rd_stat_w = rd_take_w & (avs_address_i == `TAC_OFF_INT_STAT);

    // Address decode, function used for reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    tac_ack_sampler u_sampler (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .ack_slot_i(ack_slot_i),
        .phase_i(phase_i),
        .evt_o(evt_w)
    );

    // Hardware set terms per cause bit
    assign set_w[`TAC_B_MST_DIS] = start_req_i & ~master_en_w; // [R01]
    assign set_w[`TAC_B_10RD_NORS] = start_req_i & cmd_read_i &
                                     tenbit_w & ~restart_en_w; // [R02]
    assign set_w[`TAC_B_SB_NORS] = sb_cause_w; // [R03] [R04]
    assign set_w[`TAC_B_HS_NORS] = start_req_i & hs_mode_w &
                                   ~restart_en_w; // [R06]
    assign set_w[`TAC_B_SB_ACK] = evt_w.startbyte_ack; // [R07]
    assign set_w[`TAC_B_HS_ACK] = evt_w.hscode_ack & hs_mode_w; // [R08]
    assign set_w[`TAC_B_GC_READ] = gc_sent_q & cmd_push_i &
                                   cmd_read_i; // [R09]
    assign set_w[`TAC_B_GC_NOACK] = evt_w.gcall_nack; // [R10]
    assign set_w[`TAC_B_DATA_NOACK] = evt_w.data_nack; // [R11]
    assign set_w[`TAC_B_10A2_NOACK] = evt_w.addr10b_nack; // [R12]
    assign set_w[`TAC_B_10A1_NOACK] = evt_w.addr10a_nack; // [R13]
    assign set_w[`TAC_B_7B_NOACK] = evt_w.addr7_nack; // [R14]

    // Clear drops every stored bit, but same-cycle sets other than bit 9 still land; bit 9 comes back next cycle if still caused
    always_comb begin
        cause_d = clr_abrt_w ? '0 : cause_q; // [R15] [R04]
        cause_d[CAUSE_W-1:0] = cause_d | (clr_abrt_w ?
            (set_w & ~(CAUSE_W'(1) << `TAC_B_SB_NORS)) : set_w);
    end

    // Interrupt events; set wins over the read-clear
    always_comb begin
        int_stat_d = rd_stat_w ? 2'h0 : int_stat_q;
        int_stat_d[0] = int_stat_d[0] | (|set_w);
        int_stat_d[1] = int_stat_d[1] | sb_cause_w;
    end

    // Read data selection
    always_comb begin
        rdata_d = `TAC_ZERO32;
        if (hit(avs_address_i, `TAC_OFF_CAUSE))
            rdata_d[CAUSE_W-1:0] = cause_q;
        else if (hit(avs_address_i, `TAC_OFF_CTRL))
            rdata_d = ctrl_q;
        else if (hit(avs_address_i, `TAC_OFF_TARGET))
            rdata_d = target_q;
        else if (hit(avs_address_i, `TAC_OFF_INT_STAT))
            rdata_d[1:0] = int_stat_q;
        else if (hit(avs_address_i, `TAC_OFF_INT_MASK))
            rdata_d[1:0] = int_mask_q;
        else if (hit(avs_address_i, `TAC_OFF_CLR_ABRT) |
                 hit(avs_address_i, `TAC_OFF_CLR_ALL))
            rdata_d[0] = abort_q;
    end

    // Cause register: reset to zero, no software write path
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) cause_q <= '0; // [R17]
        else cause_q <= cause_d;
    end

    // General call tracking until the next command is queued
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) gc_sent_q <= 1'b0;
        else if (cmd_push_i) gc_sent_q <= 1'b0;
        else if (start_req_i) gc_sent_q <= gc_mode_w;
    end

    // Software-written configuration
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= `TAC_CTL_RESET;
            target_q <= `TAC_ZERO32;
            int_mask_q <= 2'h0;
        end else if (wr_take_w) begin
            if (hit(avs_address_i, `TAC_OFF_CTRL)) ctrl_q <= avs_writedata_i;
            if (hit(avs_address_i, `TAC_OFF_TARGET))
                target_q <= avs_writedata_i;
            if (hit(avs_address_i, `TAC_OFF_INT_MASK))
                int_mask_q <= avs_writedata_i[1:0];
        end
    end

    // Bus answer and flags
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            avs_readdata_o <= `TAC_ZERO32;
            int_stat_q <= 2'h0;
            abort_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ack_q <= req_w;
            // Kept as its own flop so the port has no logic behind it
            wait_q <= ~req_w;
            if (req_w) avs_readdata_o <= rdata_d;
            int_stat_q <= int_stat_d;
            abort_q <= |cause_d; // [R16]
            irq_q <= |(int_stat_d & int_mask_q);
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign tx_abort_o = abort_q;
    assign irq_o = irq_q;
endmodule : tac_abort_capture

/* File: verif/tac_abort_capture_sva.sv */
// Checker for bus handshake and abort flag timing of the capture block
`include "tac_map.svh"
`timescale 1ns/1ns
module tac_abort_capture_sva (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic start_req_i,
    input wire logic cmd_push_i,
    input wire logic ack_slot_i,
    input wire logic tx_abort_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    wire req = avs_read_i || avs_write_i; // Any request up
    wire rtake = avs_read_i && !avs_waitrequest_o; // Read taken at this edge
    wire wtake = avs_write_i && !avs_waitrequest_o; // Write taken
    // Read of either clearing register taken
    wire clr = rtake && (avs_address_i == `TAC_OFF_CLR_ABRT ||
        avs_address_i == `TAC_OFF_CLR_ALL);
    // No new cause source this cycle
    wire quiet = !start_req_i && !cmd_push_i && !ack_slot_i;
    // Anything that may set a cause, config writes included
    wire src = start_req_i || cmd_push_i || ack_slot_i || wtake || clr;
    sequence s_answer;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    property p_answer;
        $rose(req) |-> s_answer;
    endproperty
    property p_once;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    property p_idle;
        !req |-> avs_waitrequest_o;
    endproperty
    property p_stands;
        !req ##1 !req |-> $stable(avs_readdata_o);
    endproperty
    property p_hole;
        rtake && avs_address_i == 8'h08 |-> avs_readdata_o == 32'h0;
    endproperty
    property p_clear;
        clr && quiet |=> !tx_abort_o;
    endproperty
    // A flag only falls through a clearing read
    property p_fall;
        $fell(tx_abort_o) |-> $past(clr);
    endproperty
    // Pin path is slow, so a source up to three edges back counts
    property p_rise;
        $rose(tx_abort_o) |-> $past(src) || $past(src, 2) || $past(src, 3);
    endproperty
    a_answer: assert property (p_answer) else $error("answer not in 1 cycle");
    a_once: assert property (p_once) else $error("waitrequest low too long");
    a_idle: assert property (p_idle) else $error("answer without request");
    a_stands: assert property (p_stands) else $error("readdata moved");
    a_hole: assert property (p_hole) else $error("unmapped read nonzero");
    a_clear: assert property (p_clear) else $error("clear missed");
    a_fall: assert property (p_fall) else $error("flag fell");
    a_rise: assert property (p_rise) else $error("flag rose");
endmodule : tac_abort_capture_sva
bind tac_abort_capture tac_abort_capture_sva tac_abort_capture_sva_inst (
    .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .start_req_i(start_req_i), .cmd_push_i(cmd_push_i),
    .ack_slot_i(ack_slot_i), .tx_abort_o(tx_abort_o));

/* File: verif/tac_slave_model.sv */
// Remote bus target model: answers one acknowledge bit on the pins
`timescale 1ns/1ns
module tac_slave_model (
    output logic scl_o,
    output logic sda_o
);
    // Idle bus pulled high, clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // One bit time at a 320 ns period; data changes only while clock low
    // Offset by 10 ns so no pin moves on a sampling clock edge
    task ack_bit(input logic ack);
        #10 scl_o = 1'b0;
        #80 sda_o = !ack; // Low acks high
        #80 scl_o = 1'b1;
        #160 scl_o = 1'b0;
        #80 sda_o = 1'b1; // Released, pull-up brings it back
        #80 scl_o = 1'b1;
    endtask : ack_bit
endmodule : tac_slave_model

/* File: verif/tb_tac_abort_capture.sv */
// Self-checking bench for the abort cause capture block
`include "tac_map.svh"
`timescale 1ns/1ns
module tb_tac_abort_capture import tac_pkg::*; ;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0; // Active low reset
    logic [7:0] addr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic start_req = 1'b0;
    logic cmd_push = 1'b0;
    logic cmd_read = 1'b0;
    logic ack_slot = 1'b0;
    tac_phase_t phase = TAC_PH_IDLE;
    wire [31:0] rdata;
    wire wait_o, tx_abort, irq, scl, sda;
    logic [31:0] q; // Last read data
    logic [31:0] e; // Expected cause word in the pin loop
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    // Event table: phase, expected bit; last two are acked
    tac_phase_t ph [7] = '{TAC_PH_ADDR7, TAC_PH_ADDR10A, TAC_PH_ADDR10B,
        TAC_PH_DATA, TAC_PH_GCALL, TAC_PH_SBYTE, TAC_PH_HSCODE};
    int bt [7] = '{0, 1, 2, 3, 4, 7, 6};
    tac_abort_capture tac_abort_capture_inst (.clock_i(clock_i),
        .nrst_i(nrst_i), .avs_address_i(addr), .avs_read_i(rd_en),
        .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_o), .start_req_i(start_req),
        .cmd_push_i(cmd_push), .cmd_read_i(cmd_read), .ack_slot_i(ack_slot),
        .phase_i(phase), .scl_i(scl), .sda_i(sda), .tx_abort_o(tx_abort),
        .irq_o(irq));
    tac_slave_model tac_slave_model_inst (.scl_o(scl), .sda_o(sda));
    always #20 clock_i = ~clock_i;
    task give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task chk_word(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task chk_bit(string nm, logic e, logic g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    // Avalon cycle: held until the rising edge that sees waitrequest low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        rd_en <= !w;
        wr_en <= w;
        addr <= a;
        wdata <= d;
        // Waitrequest low ends this wait; if it never drops, the hang guard does
        do begin
            @(posedge clock_i);
        end while (wait_o !== 1'b0);
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk_word("readback", e, q);
    endtask : rdchk
    task clear;
        bus(1'b0, `TAC_OFF_CLR_ABRT, 32'h0);
    endtask : clear
    task start;
        @(posedge clock_i);
        start_req <= 1'b1;
        @(posedge clock_i);
        start_req <= 1'b0;
    endtask : start
    task push_read;
        @(posedge clock_i);
        cmd_read <= 1'b1;
        cmd_push <= 1'b1;
        @(posedge clock_i);
        cmd_push <= 1'b0;
        cmd_read <= 1'b0;
    endtask : push_read
    initial begin
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        rdchk(`TAC_OFF_CAUSE, 32'h0);
        wr(`TAC_OFF_CAUSE, 32'h0000_0FFF);
        rdchk(`TAC_OFF_CAUSE, 32'h0);
        rdchk(8'h08, 32'h0);
        $display("test reset done");
        // Start while master disabled, with and without mask
        wr(`TAC_OFF_INT_MASK, 32'h1);
        start();
        repeat (3) @(posedge clock_i);
        chk_bit("abort flag", 1'b1, tx_abort);
        chk_bit("irq", 1'b1, irq);
        rdchk(`TAC_OFF_CAUSE, 32'h800);
        bus(1'b0, `TAC_OFF_CLR_ALL, 32'h0);
        bus(1'b0, `TAC_OFF_INT_STAT, 32'h0);
        rdchk(`TAC_OFF_CAUSE, 32'h0);
        chk_bit("irq", 1'b0, irq);
        wr(`TAC_OFF_INT_MASK, 32'h0);
        start();
        repeat (3) @(posedge clock_i);
        chk_bit("irq masked", 1'b0, irq);
        clear();
        $display("test master disabled done");
        // Causes raised by commands against config
        wr(`TAC_OFF_CTRL, 32'h11);
        // Master starts a read command in ten-bit mode
        cmd_read <= 1'b1;
        start();
        cmd_read <= 1'b0;
        rdchk(`TAC_OFF_CAUSE, 32'h400);
        clear();
        wr(`TAC_OFF_CTRL, 32'h41);
        start();
        rdchk(`TAC_OFF_CAUSE, 32'h100);
        clear();
        wr(`TAC_OFF_CTRL, 32'h21);
        wr(`TAC_OFF_TARGET, 32'h800);
        start();
        push_read();
        rdchk(`TAC_OFF_CAUSE, 32'h20);
        clear();
        $display("test command causes done");
        // START byte cause survives a clear until each of its fixes
        for (int k = 0; k < 3; k++) begin
            wr(`TAC_OFF_CTRL, 32'h1);
            wr(`TAC_OFF_TARGET, 32'hC00);
            clear();
            rdchk(`TAC_OFF_CAUSE, 32'h200);
            if (k == 0)
                wr(`TAC_OFF_CTRL, 32'h21);
            else
                wr(`TAC_OFF_TARGET, k == 1 ? 32'h400 : 32'h800);
            clear();
            rdchk(`TAC_OFF_CAUSE, 32'h0);
        end
        $display("test start byte done");
        // Acknowledge slot results seen on the pins
        wr(`TAC_OFF_CTRL, 32'h61);
        wr(`TAC_OFF_TARGET, 32'h0);
        for (int i = 0; i < 7; i++) begin
            @(posedge clock_i);
            phase <= ph[i];
            ack_slot <= 1'b1;
            tac_slave_model_inst.ack_bit(i > 4);
            @(posedge clock_i);
            ack_slot <= 1'b0;
            phase <= TAC_PH_IDLE;
            e = 32'h1 << bt[i];
            rdchk(`TAC_OFF_CAUSE, e);
            clear();
        end
        $display("test pin events done");
        // Reset in mid-run wipes a set cause
        wr(`TAC_OFF_CTRL, 32'h0);
        start();
        @(posedge clock_i);
        nrst_i <= 1'b0;
        @(posedge clock_i);
        nrst_i <= 1'b1;
        rdchk(`TAC_OFF_CAUSE, 32'h0);
        $display("test second reset done");
        give_verdict();
    end
endmodule : tb_tac_abort_capture
